// ---- hw/extended_control_serial_port.sv ----
// module: control-mode selection and serial configuration port
// Function
// - enable low: serial registers control device
// - enable high: port off, registers default
// - select low: serial clock moves data
// - select high: input ignored, output released
// - all shifting follows the controller's clock
// - phase pin: low 0 deg, high 90
// - phase applies only in demux mode
// - extended mode: phase from control bit 14
// - extended mode: I/Q ranges from registers
// - pin-mode range equals smallest register range
// - non-demux pin high 1:1, low 1:2
`timescale 1ns/10ps
`default_nettype none
module extended_control_serial_port (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              extended_control_enable_n,
  input  wire logic              serial_select_n,
  input  wire logic              serialClock,
  input  wire logic              serialDataIn,
  output logic                   serialDataOut,
  output logic                   serialDataOutEn_n,
  input  wire logic              range_select_pin,
  input  wire logic              output_phase_select_pin,
  input  wire logic              non_demux_select_pin,
  output logic                   extended_control,
  output logic                   nonDemux,
  output logic                   outputPhase90,
  output ecp_pkg::reg_word_t     iRange,
  output ecp_pkg::reg_word_t     qRange,
  output ecp_pkg::reg_word_t     mainControl
);
  import ecp_pkg::*;

  serial_frame_if link ();

  // ==========================================================
  // pin synchronisers: two flops before any logic looks
  logic [1:0] eceSync;
  logic [1:0] selSync;
  logic [1:0] clkSync;
  logic [1:0] sdiSync;
  logic [1:0] fsrSync;
  logic [1:0] phSync;
  logic [1:0] ndmSync;
  logic       clkLast;

  // reset values match each pin's idle level, so release gives no false edge
  always_ff @(posedge clk) begin
    if (srst) begin
      eceSync <= 2'h3;
    end else begin
      eceSync <= {eceSync[0], extended_control_enable_n};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      selSync <= 2'h3;
    end else begin
      selSync <= {selSync[0], serial_select_n};
    end
  end

  // serial clock is just another pin here; its edges are found below
  always_ff @(posedge clk) begin
    if (srst) begin
      clkSync <= 2'h0;
    end else begin
      clkSync <= {clkSync[0], serialClock};
    end
  end

  // data is delayed as much as the clock, so each bit meets its own edge
  always_ff @(posedge clk) begin
    if (srst) begin
      sdiSync <= 2'h0;
    end else begin
      sdiSync <= {sdiSync[0], serialDataIn};
    end
  end

  // only the high level of the range pin is legal; it is synchronised all the same
  always_ff @(posedge clk) begin
    if (srst) begin
      fsrSync <= 2'h3;
    end else begin
      fsrSync <= {fsrSync[0], range_select_pin};
    end
  end

  // phase pin keeps being sampled in extended mode; its value is then unused
  always_ff @(posedge clk) begin
    if (srst) begin
      phSync <= 2'h0;
    end else begin
      phSync <= {phSync[0], output_phase_select_pin};
    end
  end

  // non-demux pin stays live in both modes
  always_ff @(posedge clk) begin
    if (srst) begin
      ndmSync <= 2'h0;
    end else begin
      ndmSync <= {ndmSync[0], non_demux_select_pin};
    end
  end

  // a parked low clock yields no edges, so idle gaps are harmless
  always_ff @(posedge clk) begin
    if (srst) begin
      clkLast <= 1'b0;
    end else begin
      clkLast <= clkSync[1];
    end
  end

  // ==========================================================
  // mode decode
  logic ecmNow;
  logic portActive;

  assign ecmNow     = !eceSync[1];
  // dropping either the mode or the select aborts a frame at once
  assign portActive = ecmNow && !selSync[1];

  assign link.active    = portActive;
  assign link.riseEvent = clkSync[1] && !clkLast;
  assign link.fallEvent = !clkSync[1] && clkLast;
  assign link.dataIn    = sdiSync[1];

  // limitation: each serial clock level must last at least four system clocks,
  // or the synchronisers miss edges and the frame falls out of step; read bits
  // reach the pin three to four clocks after a falling edge, which bounds how
  // fast the controller may run its clock
  serial_frame_shifter shifter (
    .clk  (clk),
    .srst (srst),
    .link (link)
  );

  // ==========================================================
  // register file; leaving extended control restores defaults
  reg_word_t ctrlReg;
  reg_word_t iRangeReg;
  reg_word_t qRangeReg;

  // write enable decode, shared by the three registers
  function automatic logic writeHit(input logic       strobe,
                                    input logic [3:0] addr,
                                    input logic [3:0] target);
    writeHit = strobe && (addr == target);
  endfunction : writeHit

  // a write lands three to four clocks after the rising edge of its last bit, well before select returns high;
  // a frame cut short never raises the strobe, so it leaves the registers untouched

  always_ff @(posedge clk) begin
    if (srst || !ecmNow) begin
      ctrlReg <= MAIN_CONTROL_RST;
    end else if (writeHit(link.writeStrobe, link.address, ADDR_MAIN_CONTROL)) begin
      ctrlReg <= link.writeData;
    end
  end

  // ranges restart at their default code, not at the pin-mode minimum
  always_ff @(posedge clk) begin
    if (srst || !ecmNow) begin
      iRangeReg <= RANGE_REG_RST;
    end else if (writeHit(link.writeStrobe, link.address, ADDR_I_RANGE)) begin
      iRangeReg <= link.writeData;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || !ecmNow) begin
      qRangeReg <= RANGE_REG_RST;
    end else if (writeHit(link.writeStrobe, link.address, ADDR_Q_RANGE)) begin
      qRangeReg <= link.writeData;
    end
  end

  // unmapped addresses read as zero
  always_comb begin
    unique case (link.address)
      ADDR_MAIN_CONTROL: link.readData = ctrlReg;
      ADDR_I_RANGE:      link.readData = iRangeReg;
      ADDR_Q_RANGE:      link.readData = qRangeReg;
      default:           link.readData = 16'h0000;
    endcase
  end

  // ==========================================================
  // serial data output pin
  always_ff @(posedge clk) begin
    if (srst) begin
      serialDataOut <= 1'b0;
    end else begin
      serialDataOut <= portActive ? link.dataOut : 1'b0;
    end
  end

  // released pin is driven low behind the enable; the pad floats it
  always_ff @(posedge clk) begin
    if (srst) begin
      serialDataOutEn_n <= 1'b1;
    end else begin
      serialDataOutEn_n <= !portActive;
    end
  end

  // ==========================================================
  // mode outputs seen by the converter core
  logic      next_phase90;
  reg_word_t next_iRange;
  reg_word_t next_qRange;

  // 1:1 mode ignores the phase choice, so it stays at 0 deg
  always_comb begin
    next_phase90 = 1'b0;
    if (!ndmSync[1]) begin
      if (ecmNow) begin
        next_phase90 = ctrlReg[OUTPUT_PHASE_BIT];
      end else begin
        next_phase90 = phSync[1];
      end
    end
  end

  // with the range pin low in pin mode the setting is undefined; minimum held
  always_comb begin
    if (ecmNow) begin
      next_iRange = iRangeReg;
    end else begin
      next_iRange = RANGE_MIN;
    end
  end

  always_comb begin
    if (ecmNow) begin
      next_qRange = qRangeReg;
    end else begin
      next_qRange = RANGE_MIN;
    end
  end

  // every output is a flop, so the core never sees decode glitches
  always_ff @(posedge clk) begin
    if (srst) begin
      extended_control <= 1'b0;
    end else begin
      extended_control <= ecmNow;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      nonDemux <= 1'b0;
    end else begin
      nonDemux <= ndmSync[1];
    end
  end

  // phase and ranges go out with the mode flag, in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      outputPhase90 <= 1'b0;
    end else begin
      outputPhase90 <= next_phase90;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      iRange <= RANGE_MIN;
    end else begin
      iRange <= next_iRange;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      qRange <= RANGE_MIN;
    end else begin
      qRange <= next_qRange;
    end
  end

  // mirrored control word lets the core watch every field directly
  always_ff @(posedge clk) begin
    if (srst) begin
      mainControl <= MAIN_CONTROL_RST;
    end else begin
      mainControl <= ctrlReg;
    end
  end

endmodule : extended_control_serial_port
`default_nettype wire

// ---- hw/ecp_pkg.sv ----
// package: constants and types for the extended control serial port
package ecp_pkg;

  // ==========================================================
  // register map (4-bit serial address)
  localparam logic [3:0]  ADDR_MAIN_CONTROL = 4'h0;
  localparam logic [3:0]  ADDR_I_RANGE      = 4'h3;
  localparam logic [3:0]  ADDR_Q_RANGE      = 4'hb;

  // ==========================================================
  // field positions and reset values
  localparam int          OUTPUT_PHASE_BIT  = 14;
  localparam logic [15:0] MAIN_CONTROL_RST  = 16'h0000;
  localparam logic [15:0] RANGE_REG_RST     = 16'h4000;
  // smallest range code the range registers accept
  localparam logic [15:0] RANGE_MIN         = 16'h0000;

  // ==========================================================
  // serial frame: rw flag, 3 spare bits, 4 address bits, 16 data bits
  localparam int          FRAME_BITS        = 24;
  localparam int          HEADER_BITS       = 8;
  localparam int          RW_POS            = 23;
  localparam int          ADDR_HI           = 19;
  localparam int          ADDR_LO           = 16;
  localparam logic [4:0]  LAST_BIT_COUNT    = 5'd23;
  localparam logic [4:0]  HEADER_COUNT      = 5'd8;
  localparam logic [4:0]  COUNT_ZERO        = 5'h00;
  localparam logic [4:0]  COUNT_ONE         = 5'h01;

  // ==========================================================
  // frame state
  typedef enum logic [2:0] {
    FRAME_IDLE   = 3'b001,
    FRAME_SHIFT  = 3'b010,
    FRAME_DONE   = 3'b100
  } frame_state_t;

  typedef logic [15:0] reg_word_t;

endpackage : ecp_pkg

// ---- hw/serial_frame_if.sv ----
// interface: link between pin front end and frame shifter
`timescale 1ns/10ps
`default_nettype none
interface serial_frame_if;
  import ecp_pkg::*;
  logic        active;
  logic        riseEvent;
  logic        fallEvent;
  logic        dataIn;
  logic        dataOut;
  logic        writeStrobe;
  logic [3:0]  address;
  reg_word_t   writeData;
  reg_word_t   readData;

  modport front (output active, output riseEvent, output fallEvent, output dataIn,
                 input dataOut, input writeStrobe, input address, input writeData,
                 output readData);
  modport shifter (input active, input riseEvent, input fallEvent, input dataIn,
                   output dataOut, output writeStrobe, output address,
                   output writeData, input readData);
endinterface : serial_frame_if
`default_nettype wire

// ---- hw/serial_frame_shifter.sv ----
// module: serial frame shifter driven by sampled serial clock edges
`timescale 1ns/10ps
`default_nettype none
module serial_frame_shifter (
  input  wire logic              clk,
  input  wire logic              srst,
  serial_frame_if.shifter        link
);
  import ecp_pkg::*;

  frame_state_t state;
  logic [4:0]   bitCount;
  logic [23:0]  shiftIn;
  reg_word_t    shiftOut;
  logic         readFrame;
  logic [3:0]   addrLatch;

  // ==========================================================
  // frame sequencing; dropping the select aborts a frame cleanly
  always_ff @(posedge clk) begin
    if (srst || !link.active) begin
      state    <= FRAME_IDLE;
      bitCount <= COUNT_ZERO;
    end else if (link.riseEvent) begin
      unique case (state)
        FRAME_IDLE: begin
          state    <= FRAME_SHIFT;
          bitCount <= COUNT_ONE;
        end
        FRAME_SHIFT: begin
          bitCount <= bitCount + COUNT_ONE;
          if (bitCount == LAST_BIT_COUNT) begin
            state <= FRAME_DONE;
          end
        end
        FRAME_DONE: begin
          bitCount <= bitCount;
        end
      endcase
    end
  end

  // input bits taken on rising edges only
  always_ff @(posedge clk) begin
    if (srst) begin
      shiftIn <= 24'h000000;
    end else if (link.active && link.riseEvent && state != FRAME_DONE) begin
      shiftIn <= {shiftIn[22:0], link.dataIn};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      readFrame <= 1'b0;
    end else if (link.active && link.riseEvent && state == FRAME_IDLE) begin
      readFrame <= link.dataIn;
    end
  end

  // write commits once the last data bit is in
  always_ff @(posedge clk) begin
    if (srst) begin
      link.writeStrobe <= 1'b0;
    end else begin
      link.writeStrobe <= link.active && link.riseEvent && !readFrame
                          && state == FRAME_SHIFT && bitCount == LAST_BIT_COUNT;
    end
  end

  // address is caught with the last header bit, so a read can answer at once
  // and a write still sees it after the data bits have pushed it along
  always_ff @(posedge clk) begin
    if (srst) begin
      addrLatch <= 4'h0;
    end else if (link.active && link.riseEvent && state == FRAME_SHIFT
                 && bitCount == HEADER_COUNT - COUNT_ONE) begin
      addrLatch <= {shiftIn[ADDR_HI-ADDR_LO-1:0], link.dataIn};
    end
  end

  assign link.address   = addrLatch;
  assign link.writeData = shiftIn[15:0];

  // ==========================================================
  // read data loads after the header and moves out on falling edges
  always_ff @(posedge clk) begin
    if (srst || !link.active) begin
      shiftOut     <= 16'h0000;
      link.dataOut <= 1'b0;
    end else if (link.fallEvent) begin
      if (readFrame && state == FRAME_SHIFT && bitCount == HEADER_COUNT) begin
        link.dataOut <= link.readData[15];
        shiftOut     <= {link.readData[14:0], 1'b0};
      end else begin
        link.dataOut <= shiftOut[15];
        shiftOut     <= {shiftOut[14:0], 1'b0};
      end
    end
  end

endmodule : serial_frame_shifter
`default_nettype wire

// ---- tb/ecsp_assertions.sv ----
// checker: port-level assertions for the serial port block
`timescale 1ns/10ps
`default_nettype none
module ecsp_assertions import ecp_pkg::*; (
  input wire logic      clk,
  input wire logic      srst,
  input wire logic      extended_control_enable_n,
  input wire logic      serial_select_n,
  input wire logic      serialClock,
  input wire logic      output_phase_select_pin,
  input wire logic      non_demux_select_pin,
  input wire logic      serialDataOut,
  input wire logic      serialDataOutEn_n,
  input wire logic      extended_control,
  input wire logic      nonDemux,
  input wire logic      outputPhase90,
  input wire reg_word_t iRange,
  input wire reg_word_t qRange,
  input wire reg_word_t mainControl
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // ==========================================================
  // mode, pin and serial behaviour
  AST_MODE: assert property ($stable(extended_control_enable_n)[*5] |->
    extended_control == !extended_control_enable_n) else $error("mode flag wrong");
  AST_NDM: assert property ($stable(non_demux_select_pin)[*5] |->
    nonDemux == non_demux_select_pin) else $error("demux mode wrong");
  AST_PHASE_NDM: assert property (nonDemux[*3] |-> !outputPhase90)
    else $error("phase set in 1:1 mode");
  AST_PIN_PHASE: assert property ((!extended_control && !nonDemux &&
    $stable(output_phase_select_pin))[*4] |-> outputPhase90 == output_phase_select_pin)
    else $error("pin phase wrong");
  AST_ECM_PHASE: assert property ((extended_control && !nonDemux &&
    $stable(mainControl))[*3] |-> outputPhase90 == mainControl[OUTPUT_PHASE_BIT])
    else $error("register phase wrong");
  AST_PIN_RANGE: assert property ((!extended_control)[*3] |->
    iRange == RANGE_MIN && qRange == RANGE_MIN) else $error("pin range wrong");
  AST_ECM_RANGE: assert property ((extended_control && serial_select_n)[*4] |->
    $stable(iRange) && $stable(qRange)) else $error("range moved without frame");
  AST_RELEASE: assert property ((serial_select_n || !extended_control)[*5] |->
    serialDataOutEn_n) else $error("data out not released");
  AST_OUT_EDGE: assert property (!serialDataOutEn_n && !$past(serialDataOutEn_n) &&
    $changed(serialDataOut) |-> !$past(serialClock, 3)) else $error("data out moved late");
  AST_EXIT: assert property ($fell(extended_control) |-> ##[0:2]
    mainControl == MAIN_CONTROL_RST) else $error("control not defaulted");
endmodule : ecsp_assertions
bind extended_control_serial_port ecsp_assertions CHK (.*);
`default_nettype wire

// ---- tb/host_ctrl_model.sv ----
// model: host controller driving the serial configuration port
`timescale 1ns/10ps
`default_nettype none
module host_ctrl_model (
  output logic      sck,
  output logic      csN,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    sck = 1'b0;
    csN = 1'b1;
    mosi = 1'b0;
  end
  // ==========================================================
  // one 24-bit frame; sel low keeps select high to prove it is ignored
  task automatic frame(input logic [23:0] tx, input logic sel, output logic [15:0] rx);
    rx = 16'h0000;
    csN = !sel;
    for (int i = 23; i >= 0; i--) begin
      mosi = tx[i];
      #100;
      if (i < 16) rx = {rx[14:0], miso};
      sck = 1'b1;
      #100;
      sck = 1'b0;
    end
    #100;
    // released line shows the inverse of the last bit, never a stale value
    mosi = ~mosi;
    csN = 1'b1;
    #400;
  endtask : frame
endmodule : host_ctrl_model
`default_nettype wire

// ---- tb/test_extended_control_serial_port.sv ----
// testbench: pin and serial-register control of the serial port block
`timescale 1ns/10ps
`default_nettype none
module test_extended_control_serial_port;
  import ecp_pkg::*;
  logic      clk, srst, enableN, ndmPin, phasePin, sck, csN, mosi, miso, misoEn_n;
  logic      extMode, nonDemux, phase90;
  reg_word_t iRange, qRange, mainControl, rd;
  logic [3:0] addrs [4];
  reg_word_t vals [4];
  int        error_cnt = 0;
  int        n_tests = 0;
  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  extended_control_serial_port DUT (.clk(clk), .srst(srst), .extended_control_enable_n(enableN),
    .serial_select_n(csN), .serialClock(sck), .serialDataIn(mosi), .serialDataOut(miso),
    .serialDataOutEn_n(misoEn_n), .range_select_pin(1'b1),
    .output_phase_select_pin(phasePin), .non_demux_select_pin(ndmPin),
    .extended_control(extMode), .nonDemux(nonDemux), .outputPhase90(phase90),
    .iRange(iRange), .qRange(qRange), .mainControl(mainControl));
  host_ctrl_model HOST (.sck(sck), .csN(csN), .mosi(mosi), .miso(miso));
  // ==========================================================
  // tasks
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic xfer(input logic rw, input logic [3:0] a, input reg_word_t d, input logic s);
    HOST.frame({rw, 3'h0, a, d}, s, rd);
    repeat (6) @(negedge clk);
  endtask : xfer
  task automatic pins(input logic e, input logic n, input logic p);
    @(negedge clk);
    enableN = e;
    ndmPin = n;
    phasePin = p;
    repeat (6) @(negedge clk);
  endtask : pins
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  // ==========================================================
  // sequence
  initial begin
    srst = 1'b1;
    {enableN, ndmPin, phasePin} = 3'b100;
    addrs = '{ADDR_MAIN_CONTROL, ADDR_I_RANGE, ADDR_Q_RANGE, 4'h5};
    vals = '{16'h4a5c, 16'h1234, 16'habcd, 16'h5a5a};
    repeat (20) @(negedge clk);
    srst = 1'b0;
    for (int k = 0; k < 4; k++) begin
      pins(1'b1, k[1], k[0]);
      check("nonDemux", 16'(k[1]), 16'(nonDemux));
      check("phase90", 16'(k[0] & ~k[1]), 16'(phase90));
      check("iRange", RANGE_MIN, iRange);
      check("qRange", RANGE_MIN, qRange);
    end
    xfer(1'b0, ADDR_MAIN_CONTROL, 16'hffff, 1'b1);
    check("mainControl", MAIN_CONTROL_RST, mainControl);
    pins(1'b0, 1'b0, 1'b1);
    check("extMode", 16'h0001, 16'(extMode));
    check("phase90", 16'h0000, 16'(phase90));
    check("iRange", RANGE_REG_RST, iRange);
    for (int k = 0; k < 4; k++) xfer(1'b0, addrs[k], vals[k], 1'b1);
    for (int k = 0; k < 4; k++) begin
      xfer(1'b1, addrs[k], 16'h0000, 1'b1);
      check("readback", (k == 3) ? 16'h0000 : vals[k], rd);
    end
    check("iRange", 16'h1234, iRange);
    check("qRange", 16'habcd, qRange);
    pins(1'b0, 1'b0, 1'b0);
    check("phase90", 16'h0001, 16'(phase90));
    pins(1'b0, 1'b1, 1'b0);
    check("phase90", 16'h0000, 16'(phase90));
    xfer(1'b0, ADDR_I_RANGE, 16'h0077, 1'b0);
    check("iRange", 16'h1234, iRange);
    check("misoEn_n", 16'h0001, 16'(misoEn_n));
    pins(1'b1, 1'b0, 1'b0);
    check("mainControl", MAIN_CONTROL_RST, mainControl);
    check("iRange", RANGE_MIN, iRange);
    pins(1'b0, 1'b0, 1'b1);
    check("qRange", RANGE_REG_RST, qRange);
    check("phase90", 16'h0000, 16'(phase90));
    wrap_up();
  end
  initial begin
    #300us;
    error_cnt++;
    wrap_up();
  end
endmodule : test_extended_control_serial_port
`default_nettype wire
